// ==== rtl/mcct_timer.sv ====
/*
  Multimode capture/compare timer: 16-bit counter, two general registers,
  output compare, PWM and two-phase counting, with status and request.
  Assumes control ports are on core_clk and steady while counting;
  pins and ext clocks are asynchronous and are synchronised inside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcct_defines.svh"

// Overview of operation
// - Clear source 00: free run, 65536 period
// - Clear 01/10: zero at GRA/GRB match
// - Run bit 1 counts, 0 stops
// - Compare match drives pin low, high, toggle
// - Each pin selectable as port or compare
// - Compare match and overflow raise requests
// - PWM: A match high, B match low
// - Pin A compare/capture/PWM; pin B compare/capture
// - Phase mode counts per eight enable bits
// - Phase mode: capture, match, overflow, underflow requests
// - Ext pins are phases in phase mode
// - Source: clock /1,/2,/4,/8,/32 or external edge
// - Event input can trigger capture B
// - Software reads and writes the count
// - Capture, compare, PWM usable in phase mode
// - Flags for A, B, underflow, overflow, direction
// - Per-event enables gate the request
// - Source code 110 reserved, never counts outside phase mode
// - Event capture needs enable, B control 100
module mcct_timer
  import mcct_pkg::*;
#(
  parameter int unsigned CNT_W = `MCCT_CNT_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              count_run_bit,
  input  wire logic              pwm_mode_bit,
  input  wire logic              phase_mode_bit,
  input  wire logic [2:0]        count_source_sel,
  input  wire logic [1:0]        ext_edge_sel,
  input  wire logic [1:0]        clear_source,
  input  wire logic [7:0]        phase_count_enable,
  input  wire logic [2:0]        a_control,
  input  wire logic [2:0]        b_control,
  input  wire logic              event_capture_enable,
  input  wire logic              event_link_unit,
  input  wire logic              event_a_irq_enable,
  input  wire logic              event_b_irq_enable,
  input  wire logic              underflow_irq_enable,
  input  wire logic              overflow_irq_enable,
  input  wire logic              counter_wr,
  input  wire logic [CNT_W-1:0]  counter_wr_data,
  input  wire logic              gra_wr,
  input  wire logic [CNT_W-1:0]  gra_wr_data,
  input  wire logic              grb_wr,
  input  wire logic [CNT_W-1:0]  grb_wr_data,
  input  wire logic [3:0]        flag_clear,
  input  wire logic              ext_clock_pin_a,
  input  wire logic              ext_clock_pin_b,
  input  wire logic              capcomp_pin_a_i,
  input  wire logic              capcomp_pin_b_i,
  output logic                   capcomp_pin_a_o,
  output logic                   capcomp_pin_a_oe,
  output logic                   capcomp_pin_b_o,
  output logic                   capcomp_pin_b_oe,
  output logic [CNT_W-1:0]       counter_value,
  output logic [CNT_W-1:0]       general_reg_a,
  output logic [CNT_W-1:0]       general_reg_b,
  output logic                   event_a_flag,
  output logic                   event_b_flag,
  output logic                   underflow_flag,
  output logic                   overflow_flag,
  output logic                   direction_flag,
  output logic                   irq_request
);

  generate
    if (CNT_W != `MCCT_CNT_W) begin : g_bad_width
      $error("counter width must match the shared state type");
    end
  endgenerate

  mcct_src_if        src ();
  mcct_core_state_t  st;
  mcct_core_state_t  next_st;
  logic              tick;
  logic              count_up;
  logic              match_a;
  logic              match_b;
  logic              clear_hit;
  logic              ovf_set;
  logic              udf_set;
  logic              cap_a;
  logic              cap_b;
  logic              edge_a;
  logic              edge_b;
  logic              event_cap_ok;
  logic [3:0]        flag_set;

  ////////////////////////////////////////////////////////////////////////
  // Count source stage
  assign src.source_sel   = count_source_sel;
  assign src.ext_edge_sel = ext_edge_sel;
  assign src.phase_mode   = phase_mode_bit;
  assign src.phase_en     = phase_count_enable;

  mcct_count_source #(
    .PRESCALE_W (`MCCT_PRESCALE_W)
  ) u_source (
    .core_clk        (core_clk),
    .rst             (rst),
    .ext_clock_pin_a (ext_clock_pin_a),
    .ext_clock_pin_b (ext_clock_pin_b),
    .capcomp_pin_a_i (capcomp_pin_a_i),
    .capcomp_pin_b_i (capcomp_pin_b_i),
    .bus             (src.src)
  );

  ////////////////////////////////////////////////////////////////////////
  // Capture edge selection: 00 rising, 01 falling, 1x both
  always_comb begin
    case (a_control[1:0])
      2'h0:    edge_a = src.pin_a_rise;
      2'h1:    edge_a = src.pin_a_fall;
      default: edge_a = src.pin_a_rise | src.pin_a_fall;
    endcase
    case (b_control[1:0])
      2'h0:    edge_b = src.pin_b_rise;
      2'h1:    edge_b = src.pin_b_fall;
      default: edge_b = src.pin_b_rise | src.pin_b_fall;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st  = st;
    tick     = count_run_bit & src.tick;
    count_up = phase_mode_bit ? src.up : 1'b1;
    // Matches only count when the counter is about to move
    match_a  = tick & (st.cnt == st.gra);
    match_b  = tick & (st.cnt == st.grb);
    clear_hit = ((clear_source == `MCCT_CLR_GRA) & match_a) |
                ((clear_source == `MCCT_CLR_GRB) & match_b);
    ovf_set  = tick & ~clear_hit & count_up & (&st.cnt);
    udf_set  = tick & ~clear_hit & ~count_up & ~(|st.cnt);

    // Counter: free run wraps, match clears to zero
    if (tick) begin
      next_st.flags[`MCCT_FLAG_DIR] = count_up;
      if (clear_hit) begin
        next_st.cnt = '0;
      end else if (count_up) begin
        next_st.cnt = st.cnt + 1'b1;
      end else begin
        next_st.cnt = st.cnt - 1'b1;
      end
    end
    // Software write beats any clear or count
    if (counter_wr) begin
      next_st.cnt = counter_wr_data;
    end

    // Capture, also in phase mode
    event_cap_ok = event_capture_enable & ~pwm_mode_bit &
                   (b_control == `MCCT_CAP_RISE_CODE);
    cap_a = count_run_bit & ~pwm_mode_bit & a_control[`MCCT_CTL_CAPTURE] & edge_a;
    cap_b = count_run_bit & ~pwm_mode_bit & b_control[`MCCT_CTL_CAPTURE] &
            (edge_b | (event_cap_ok & event_link_unit));
    // A capture outranks a same-cycle software load
    if (cap_a) begin
      next_st.gra = st.cnt;
    end else if (gra_wr) begin
      next_st.gra = gra_wr_data;
    end
    if (cap_b) begin
      next_st.grb = st.cnt;
    end else if (grb_wr) begin
      next_st.grb = grb_wr_data;
    end

    // Pin A: PWM set at A, reset at B; B wins a tie
    if (pwm_mode_bit) begin
      if (match_b) begin
        next_st.pin_a = 1'b0;
      end else if (match_a) begin
        next_st.pin_a = 1'b1;
      end
    end else if (!a_control[`MCCT_CTL_CAPTURE] && match_a) begin
      case (a_control[1:0])
        `MCCT_OUT_LOW:    next_st.pin_a = 1'b0;
        `MCCT_OUT_HIGH:   next_st.pin_a = 1'b1;
        `MCCT_OUT_TOGGLE: next_st.pin_a = ~st.pin_a;
        default:          next_st.pin_a = st.pin_a;
      endcase
    end
    if (!pwm_mode_bit && !b_control[`MCCT_CTL_CAPTURE] && match_b) begin
      case (b_control[1:0])
        `MCCT_OUT_LOW:    next_st.pin_b = 1'b0;
        `MCCT_OUT_HIGH:   next_st.pin_b = 1'b1;
        `MCCT_OUT_TOGGLE: next_st.pin_b = ~st.pin_b;
        default:          next_st.pin_b = st.pin_b;
      endcase
    end

    // Sticky flags; a same-cycle event beats the clear
    flag_set[`MCCT_FLAG_A]   = cap_a | (match_a & (pwm_mode_bit | ~a_control[`MCCT_CTL_CAPTURE]));
    flag_set[`MCCT_FLAG_B]   = cap_b | (match_b & (pwm_mode_bit | ~b_control[`MCCT_CTL_CAPTURE]));
    flag_set[`MCCT_FLAG_UDF] = udf_set;
    flag_set[`MCCT_FLAG_OVF] = ovf_set;
    next_st.flags[3:0] = (st.flags[3:0] & ~flag_clear) | flag_set;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign counter_value   = st.cnt;
  assign general_reg_a   = st.gra;
  assign general_reg_b   = st.grb;
  assign event_a_flag    = st.flags[`MCCT_FLAG_A];
  assign event_b_flag    = st.flags[`MCCT_FLAG_B];
  assign underflow_flag  = st.flags[`MCCT_FLAG_UDF];
  assign overflow_flag   = st.flags[`MCCT_FLAG_OVF];
  assign direction_flag  = st.flags[`MCCT_FLAG_DIR];

  // Only enabled flags reach the request line
  assign irq_request = (st.flags[`MCCT_FLAG_A]   & event_a_irq_enable)  |
                       (st.flags[`MCCT_FLAG_B]   & event_b_irq_enable)  |
                       (st.flags[`MCCT_FLAG_UDF] & underflow_irq_enable) |
                       (st.flags[`MCCT_FLAG_OVF] & overflow_irq_enable);

  // Outside PWM, action code 00 leaves the pin a plain port; pin B stays port in PWM
  assign capcomp_pin_a_o  = st.pin_a;
  assign capcomp_pin_a_oe = pwm_mode_bit |
                            (~a_control[`MCCT_CTL_CAPTURE] & (a_control[1:0] != `MCCT_OUT_PORT));
  assign capcomp_pin_b_o  = st.pin_b;
  assign capcomp_pin_b_oe = ~pwm_mode_bit & ~b_control[`MCCT_CTL_CAPTURE] &
                            (b_control[1:0] != `MCCT_OUT_PORT);

endmodule

`default_nettype wire

// ==== rtl/mcct_defines.svh ====
/*
  Encodings and field codes of the multimode capture/compare timer.
  Assumes it is included by the package and by the timer modules.
*/
`ifndef MCCT_DEFINES_SVH
`define MCCT_DEFINES_SVH

`define MCCT_CNT_W          16
`define MCCT_PRESCALE_W     5
// Count source select codes
`define MCCT_SRC_DIV1       3'h0
`define MCCT_SRC_DIV2       3'h1
`define MCCT_SRC_DIV4       3'h2
`define MCCT_SRC_DIV8       3'h3
`define MCCT_SRC_DIV32      3'h4
`define MCCT_SRC_EXT_A      3'h5
`define MCCT_SRC_RESERVED   3'h6
`define MCCT_SRC_EXT_B      3'h7
// External clock valid edge
`define MCCT_EDGE_RISE      2'h0
`define MCCT_EDGE_FALL      2'h1
// Clear source codes
`define MCCT_CLR_FREE       2'h0
`define MCCT_CLR_GRA        2'h1
`define MCCT_CLR_GRB        2'h2
// Pin control: bit 2 selects capture, bits 1:0 the action
`define MCCT_CTL_CAPTURE    2
`define MCCT_OUT_PORT       2'h0
`define MCCT_OUT_LOW        2'h1
`define MCCT_OUT_HIGH       2'h2
`define MCCT_OUT_TOGGLE     2'h3
`define MCCT_CAP_RISE_CODE  3'h4
// Status flag positions
`define MCCT_FLAG_A         0
`define MCCT_FLAG_B         1
`define MCCT_FLAG_UDF       2
`define MCCT_FLAG_OVF       3
`define MCCT_FLAG_DIR       4

`endif

// ==== rtl/mcct_pkg.sv ====
/*
  Types shared by the timer core and its count source stage.
  Assumes mcct_defines.svh is on the include path.
*/
`include "mcct_defines.svh"

package mcct_pkg;

  typedef logic [`MCCT_CNT_W-1:0] mcct_count_t;

  // Synchroniser and edge history of the four input pins, and the prescaler
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [`MCCT_PRESCALE_W-1:0] prescale;
  } mcct_src_state_t;

  typedef struct packed {
    mcct_count_t cnt;
    mcct_count_t gra;
    mcct_count_t grb;
    logic        pin_a;
    logic        pin_b;
    logic [4:0]  flags;
  } mcct_core_state_t;

endpackage

// ==== rtl/mcct_src_if.sv ====
/*
  Carrier between the timer core and its count source stage.
  Assumes both ends share core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

interface mcct_src_if;
  logic [2:0] source_sel;
  logic [1:0] ext_edge_sel;
  logic       phase_mode;
  logic [7:0] phase_en;
  logic       tick;
  logic       up;
  logic       pin_a_rise;
  logic       pin_a_fall;
  logic       pin_b_rise;
  logic       pin_b_fall;

  modport core (output source_sel, ext_edge_sel, phase_mode, phase_en,
                input  tick, up, pin_a_rise, pin_a_fall, pin_b_rise, pin_b_fall);
  modport src  (input  source_sel, ext_edge_sel, phase_mode, phase_en,
                output tick, up, pin_a_rise, pin_a_fall, pin_b_rise, pin_b_fall);
endinterface

`default_nettype wire

// ==== rtl/mcct_count_source.sv ====
/*
  Count source stage: pin synchronisers, prescaler, external edge and
  two-phase decoding. Assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcct_defines.svh"

module mcct_count_source
  import mcct_pkg::*;
#(
  parameter int unsigned PRESCALE_W = `MCCT_PRESCALE_W
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ext_clock_pin_a,
  input  wire logic ext_clock_pin_b,
  input  wire logic capcomp_pin_a_i,
  input  wire logic capcomp_pin_b_i,
  mcct_src_if.src   bus
);

  generate
    if (PRESCALE_W != `MCCT_PRESCALE_W) begin : g_bad_width
      $error("prescaler must be five bits for the divide-by-32 tap");
    end
  endgenerate

  mcct_src_state_t st;
  mcct_src_state_t next_st;
  logic [3:0]      rise;
  logic [3:0]      fall;
  logic            clk_a;
  logic            clk_b;
  logic            ext_tick;
  logic [7:0]      cond;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st          = st;
    // The first stage feeds only the second; the second stage and prev feed the edge logic
    next_st.sync1    = {capcomp_pin_b_i, capcomp_pin_a_i, ext_clock_pin_b, ext_clock_pin_a};
    next_st.sync2    = st.sync1;
    next_st.prev     = st.sync2;
    next_st.prescale = st.prescale + 1'b1;
    rise             = st.sync2 & ~st.prev;
    fall             = ~st.sync2 & st.prev;
    clk_a            = st.sync2[0];
    clk_b            = st.sync2[1];
    // Two-phase conditions, four up then four down
    cond[0] = rise[0] & ~clk_b;
    cond[1] = fall[0] &  clk_b;
    cond[2] = rise[1] &  clk_a;
    cond[3] = fall[1] & ~clk_a;
    cond[4] = rise[0] &  clk_b;
    cond[5] = fall[0] & ~clk_b;
    cond[6] = rise[1] & ~clk_a;
    cond[7] = fall[1] &  clk_a;
    cond    = cond & bus.phase_en;
    case (bus.ext_edge_sel)
      `MCCT_EDGE_RISE: ext_tick = (bus.source_sel == `MCCT_SRC_EXT_A) ? rise[0] : rise[1];
      `MCCT_EDGE_FALL: ext_tick = (bus.source_sel == `MCCT_SRC_EXT_A) ? fall[0] : fall[1];
      default:         ext_tick = (bus.source_sel == `MCCT_SRC_EXT_A) ? (rise[0] | fall[0])
                                                                        : (rise[1] | fall[1]);
    endcase
  end

  // Count enable pulses on core_clk
  always_comb begin
    bus.up = 1'b1;
    if (bus.phase_mode) begin
      bus.tick = |cond;
      bus.up   = |cond[3:0];
    end else begin
      case (bus.source_sel)
        `MCCT_SRC_DIV1:  bus.tick = 1'b1;
        `MCCT_SRC_DIV2:  bus.tick = st.prescale[0];
        `MCCT_SRC_DIV4:  bus.tick = &st.prescale[1:0];
        `MCCT_SRC_DIV8:  bus.tick = &st.prescale[2:0];
        `MCCT_SRC_DIV32: bus.tick = &st.prescale[4:0];
        `MCCT_SRC_EXT_A: bus.tick = ext_tick;
        `MCCT_SRC_EXT_B: bus.tick = ext_tick;
        default:         bus.tick = 1'b0;
      endcase
    end
  end

  assign bus.pin_a_rise = rise[2];
  assign bus.pin_a_fall = fall[2];
  assign bus.pin_b_rise = rise[3];
  assign bus.pin_b_fall = fall[3];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

`default_nettype wire

// ==== dv/mcct_props.sv ====
/*
  Port checker of the timer, bound to mcct_timer.
  Assumes one clock domain and the control encodings of the defines.
*/
`timescale 1ns/1ns
`default_nettype none

module mcct_props
  import mcct_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             count_run_bit,
  input wire logic             pwm_mode_bit,
  input wire logic             phase_mode_bit,
  input wire logic [2:0]       count_source_sel,
  input wire logic [1:0]       clear_source,
  input wire logic [2:0]       a_control,
  input wire logic [2:0]       b_control,
  input wire logic             event_capture_enable,
  input wire logic             event_link_unit,
  input wire logic             event_a_irq_enable,
  input wire logic             event_b_irq_enable,
  input wire logic             underflow_irq_enable,
  input wire logic             overflow_irq_enable,
  input wire logic             counter_wr,
  input wire logic [CNT_W-1:0] counter_wr_data,
  input wire logic             grb_wr,
  input wire logic             capcomp_pin_a_o,
  input wire logic             capcomp_pin_a_oe,
  input wire logic             capcomp_pin_b_oe,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [CNT_W-1:0] general_reg_a,
  input wire logic [CNT_W-1:0] general_reg_b,
  input wire logic             event_a_flag,
  input wire logic             event_b_flag,
  input wire logic             underflow_flag,
  input wire logic             overflow_flag,
  input wire logic             irq_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  // Undivided tick with no write competing for the counter
  logic tick1;
  assign tick1 = count_run_bit && count_source_sel == 3'h0 && !phase_mode_bit && !counter_wr;

  sequence s_wrap;
    tick1 && clear_source == 2'h0 && counter_value == 16'hFFFF;
  endsequence
  sequence s_clear_a;
    tick1 && clear_source == 2'h1 && counter_value == general_reg_a
      && (pwm_mode_bit || !a_control[2]);
  endsequence
  sequence s_pwm_rise;
    tick1 && pwm_mode_bit && counter_value == general_reg_a && counter_value != general_reg_b;
  endsequence
  sequence s_evt_cap;
    event_link_unit && event_capture_enable && b_control == 3'h4 && !pwm_mode_bit
      && count_run_bit;
  endsequence

  ////////////////////////////////////////////////////////////
  chk_free_wrap: assert property (s_wrap |=> counter_value == '0 && overflow_flag)
    else $error("free run wrap wrong");
  chk_match_clear: assert property (s_clear_a |=> counter_value == '0 && event_a_flag)
    else $error("clear at match A wrong");
  chk_pwm_rise: assert property (s_pwm_rise |=> capcomp_pin_a_o)
    else $error("pwm output did not rise");
  chk_event_cap: assert property (s_evt_cap |=> general_reg_b == $past(counter_value)
    && event_b_flag) else $error("event capture wrong");
  chk_pwm_no_evt: assert property (pwm_mode_bit && event_link_unit && !grb_wr
    |=> $stable(general_reg_b)) else $error("capture in pwm mode");
  chk_stop_hold: assert property (!count_run_bit && !counter_wr |=> $stable(counter_value))
    else $error("counter moved while stopped");
  chk_reserved_src: assert property (count_source_sel == 3'h6 && !phase_mode_bit
    && !counter_wr |=> $stable(counter_value)) else $error("reserved source counted");
  chk_cnt_write: assert property (counter_wr |=> counter_value == $past(counter_wr_data))
    else $error("counter write lost");
  chk_irq_gate: assert property (irq_request == ((event_a_flag && event_a_irq_enable)
    || (event_b_flag && event_b_irq_enable) || (underflow_flag && underflow_irq_enable)
    || (overflow_flag && overflow_irq_enable))) else $error("request gating wrong");
  chk_pwm_b_port: assert property (pwm_mode_bit |-> !capcomp_pin_b_oe)
    else $error("pin B driven in pwm");
  chk_port_pin: assert property (!pwm_mode_bit && a_control == 3'h0 |-> !capcomp_pin_a_oe)
    else $error("pin A driven as port");
endmodule

bind mcct_timer mcct_props #(.CNT_W(CNT_W)) u_props (
  .core_clk, .rst, .count_run_bit, .pwm_mode_bit, .phase_mode_bit, .count_source_sel,
  .clear_source, .a_control, .b_control, .event_capture_enable, .event_link_unit,
  .event_a_irq_enable, .event_b_irq_enable, .underflow_irq_enable, .overflow_irq_enable,
  .counter_wr, .counter_wr_data, .grb_wr, .capcomp_pin_a_o, .capcomp_pin_a_oe,
  .capcomp_pin_b_oe, .counter_value, .general_reg_a, .general_reg_b, .event_a_flag,
  .event_b_flag, .underflow_flag, .overflow_flag, .irq_request
);

`default_nettype wire

// ==== dv/mcct_encoder_model.sv ====
/*
  Two-phase encoder driving the external clock pins.
  Assumes the caller steps it from a procedure on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module mcct_encoder_model (
  input  wire logic core_clk,
  output logic      phase_a,
  output logic      phase_b
);
  logic [1:0] pos = 2'h0;

  // Gray order 00,10,11,01: A leads B when stepping up
  assign phase_a = pos[1] ^ pos[0];
  assign phase_b = pos[1];

  // Lines stand still for hold cycles, slow or prompt as asked
  task automatic step(input logic up, input int hold);
    @(posedge core_clk);
    pos <= up ? pos + 2'h1 : pos - 2'h1;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
/*
  Self-checking bench of the timer with an encoder partner.
  Assumes the checker file is compiled beside it.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) \
  n_checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
  end

module testbench
  import mcct_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst, count_run_bit, pwm_mode_bit, phase_mode_bit, event_capture_enable;
  logic        event_link_unit, event_a_irq_enable, event_b_irq_enable, underflow_irq_enable;
  logic        overflow_irq_enable, counter_wr, gra_wr, grb_wr, capcomp_pin_a_i;
  logic        capcomp_pin_b_i, ext_clock_pin_a, ext_clock_pin_b, capcomp_pin_a_o;
  logic        capcomp_pin_a_oe, capcomp_pin_b_o, capcomp_pin_b_oe, irq_request;
  logic        event_a_flag, event_b_flag, underflow_flag, overflow_flag, direction_flag;
  logic [2:0]  count_source_sel, a_control, b_control;
  logic [1:0]  ext_edge_sel, clear_source;
  logic [7:0]  phase_count_enable;
  logic [3:0]  flag_clear;
  logic [4:0]  flags;
  mcct_count_t counter_wr_data, gra_wr_data, grb_wr_data;
  mcct_count_t counter_value, general_reg_a, general_reg_b;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [2:0]  sel_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  mcct_count_t cnt_tab [6] = '{16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0002, 16'h0000};

  assign flags = {direction_flag, overflow_flag, underflow_flag, event_b_flag, event_a_flag};

  always #10 core_clk = ~core_clk;

  mcct_timer dut (
    .core_clk, .rst, .count_run_bit, .pwm_mode_bit, .phase_mode_bit, .count_source_sel,
    .ext_edge_sel, .clear_source, .phase_count_enable, .a_control, .b_control,
    .event_capture_enable, .event_link_unit, .event_a_irq_enable, .event_b_irq_enable,
    .underflow_irq_enable, .overflow_irq_enable, .counter_wr, .counter_wr_data, .gra_wr,
    .gra_wr_data, .grb_wr, .grb_wr_data, .flag_clear, .ext_clock_pin_a, .ext_clock_pin_b,
    .capcomp_pin_a_i, .capcomp_pin_b_i, .capcomp_pin_a_o, .capcomp_pin_a_oe, .capcomp_pin_b_o,
    .capcomp_pin_b_oe, .counter_value, .general_reg_a, .general_reg_b, .event_a_flag,
    .event_b_flag, .underflow_flag, .overflow_flag, .direction_flag, .irq_request
  );

  mcct_encoder_model enc (
    .core_clk (core_clk),
    .phase_a  (ext_clock_pin_a),
    .phase_b  (ext_clock_pin_b)
  );

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic load(input mcct_count_t v, input mcct_count_t ga, input mcct_count_t gb);
    @(posedge core_clk);
    {counter_wr, gra_wr, grb_wr} <= 3'h7;
    counter_wr_data <= v;
    gra_wr_data <= ga;
    grb_wr_data <= gb;
    @(posedge core_clk);
    {counter_wr, gra_wr, grb_wr} <= 3'h0;
  endtask

  // Exactly n edges see the run bit, so n undivided ticks
  task automatic run(input int n);
    @(posedge core_clk);
    count_run_bit <= 1'b1;
    repeat (n) @(posedge core_clk);
    count_run_bit <= 1'b0;
    #1;
  endtask

  task automatic clr_flags();
    @(posedge core_clk);
    flag_clear <= 4'hF;
    @(posedge core_clk);
    flag_clear <= 4'h0;
  endtask

  task automatic pulse_event();
    @(posedge core_clk);
    count_run_bit <= 1'b1;
    event_link_unit <= 1'b1;
    @(posedge core_clk);
    event_link_unit <= 1'b0;
    count_run_bit <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    {count_run_bit, pwm_mode_bit, phase_mode_bit, event_capture_enable} = 4'h0;
    {event_link_unit, event_a_irq_enable, event_b_irq_enable, underflow_irq_enable} = 4'h0;
    {counter_wr, gra_wr, grb_wr, capcomp_pin_a_i, capcomp_pin_b_i} = 5'h00;
    overflow_irq_enable = 1'b1;
    {count_source_sel, a_control, b_control} = 9'h000;
    {ext_edge_sel, clear_source, flag_clear} = 8'h00;
    phase_count_enable = 8'h00;
    {counter_wr_data, gra_wr_data, grb_wr_data} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK("cnt_reset", 16'h0000, counter_value)
    `CHK("flags_reset", 5'h00, flags)
    load(16'hFFFD, 16'h0100, 16'h0100);
    run(3);
    `CHK("wrap_cnt", 16'h0000, counter_value)
    `CHK("wrap_flags", 5'h18, flags)
    `CHK("ovf_irq", 1'b1, irq_request)
    repeat (5) @(posedge core_clk);
    overflow_irq_enable <= 1'b0;
    #1;
    `CHK("stop_cnt", 16'h0000, counter_value)
    `CHK("masked_irq", 1'b0, irq_request)
    foreach (sel_tab[i]) begin
      count_source_sel <= sel_tab[i];
      load(16'h0000, 16'hFFF0, 16'hFFF0);
      run(64);
      `CHK("div_ticks", cnt_tab[i], counter_value)
    end
    count_source_sel <= 3'h0;
    clear_source <= 2'h1;
    a_control <= 3'h3;
    clr_flags();
    load(16'h0000, 16'h0004, 16'h0002);
    run(7);
    `CHK("clr_a_cnt", 16'h0002, counter_value)
    `CHK("toggle_a", 1'b1, capcomp_pin_a_o)
    `CHK("oe_a", 1'b1, capcomp_pin_a_oe)
    `CHK("oe_b_port", 1'b0, capcomp_pin_b_oe)
    `CHK("flag_a", 1'b1, event_a_flag)
    clear_source <= 2'h2;
    a_control <= 3'h1;
    b_control <= 3'h2;
    load(16'h0000, 16'h0001, 16'h0002);
    run(7);
    `CHK("clr_b_cnt", 16'h0001, counter_value)
    `CHK("low_a", 1'b0, capcomp_pin_a_o)
    `CHK("high_b", 1'b1, capcomp_pin_b_o)
    pwm_mode_bit <= 1'b1;
    load(16'h0000, 16'h0002, 16'h0005);
    run(3);
    `CHK("pwm_high", 1'b1, capcomp_pin_a_o)
    `CHK("pwm_b_port", 1'b0, capcomp_pin_b_oe)
    run(3);
    `CHK("pwm_low", 1'b0, capcomp_pin_a_o)
    `CHK("pwm_period", 16'h0000, counter_value)
    count_source_sel <= 3'h6;
    clear_source <= 2'h0;
    b_control <= 3'h4;
    event_capture_enable <= 1'b1;
    load(16'h1234, 16'h0100, 16'h0005);
    clr_flags();
    pulse_event();
    `CHK("pwm_no_cap", 16'h0005, general_reg_b)
    pwm_mode_bit <= 1'b0;
    pulse_event();
    `CHK("evt_cap", 16'h1234, general_reg_b)
    `CHK("evt_flag", 1'b1, event_b_flag)
    a_control <= 3'h4;
    clr_flags();
    @(posedge core_clk);
    count_run_bit <= 1'b1;
    capcomp_pin_a_i <= 1'b1;
    repeat (6) @(posedge core_clk);
    count_run_bit <= 1'b0;
    #1;
    `CHK("pin_cap", 16'h1234, general_reg_a)
    `CHK("pin_cap_flag", 1'b1, event_a_flag)
    {a_control, b_control} <= 6'h00;
    phase_mode_bit <= 1'b1;
    phase_count_enable <= 8'hFF;
    underflow_irq_enable <= 1'b1;
    load(16'h0001, 16'h0100, 16'h0100);
    clr_flags();
    @(posedge core_clk);
    count_run_bit <= 1'b1;
    enc.step(1'b0, 8);
    enc.step(1'b0, 8);
    #1;
    `CHK("phase_down", 16'hFFFF, counter_value)
    `CHK("udf_flags", 5'h04, flags)
    `CHK("udf_irq", 1'b1, irq_request)
    enc.step(1'b1, 8);
    #1;
    `CHK("phase_up", 16'h0000, counter_value)
    `CHK("ovf_flags", 5'h1C, flags)
    // Ext clock A, both edges: four encoder steps give two edges on line A
    phase_mode_bit <= 1'b0;
    count_source_sel <= 3'h5;
    ext_edge_sel <= 2'h2;
    repeat (4) enc.step(1'b1, 8);
    #1;
    `CHK("ext_ticks", 16'h0002, counter_value)
    final_report();
  end
endmodule

`default_nettype wire
